// ==== deac_array_model.sv ====
// Behavioural model of the nonvolatile byte array behind the controller
`timescale 1ns/1ps
module deac_array_model (
    // Clock
    input wire logic clk_i,
    // Controller side
    input wire logic [9:0] nv_addr_i,
    input wire logic [7:0] nv_wdata_i,
    input wire logic nv_rd_i,
    input wire logic data_wr_i,
    output logic [7:0] nv_rdata_o
);
    logic [7:0] mem [1024];
    logic [7:0] last_r;
    logic wr_d_r;

    initial begin
        for (int k = 0; k < 1024; k++) begin
            mem[k] = 8'hFF;
        end
        last_r = 8'h00;
        wr_d_r = 1'b0;
    end

    always @(posedge clk_i) begin
        wr_d_r <= data_wr_i;
        // Byte stored as the timed write starts
        if (data_wr_i && !wr_d_r) begin
            mem[nv_addr_i] <= nv_wdata_i;
        end
        // Off-cycle data toggles so stale bytes never look valid
        if (nv_rd_i) begin
            last_r <= mem[nv_addr_i];
        end else begin
            last_r <= ~last_r;
        end
    end

    // One-cycle read of the addressed byte
    assign nv_rdata_o = nv_rd_i ? mem[nv_addr_i] : last_r;
endmodule

// ==== deac_ctrl.sv ====
// Data array access controller with APB register slave
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - code_space_select picks flash over data array
// - settings_space_select routes to configuration space
// - allow_program cleared at reset, software only
// - program_launch set by software, cleared by hardware
// - fetch loads byte next cycle, self-clears
// - fetch ignored in flash or configuration space
// - Key port stores nothing, reads zero
// - Launch needs 0x55 then 0xAA first
// - allow_program must precede launch write
// - Busy write freezes control, address, buffer
// - Completion clears launch, sets write_done_flag
// - Abort flag on reset or improper launch
// - Abort leaves space selects untouched
// - Row erase on flash-space launch only, cleared when done
// - Launch starts self-timed array operation
// - Buffer keeps last read or written byte
// - Slow crystal mode stalls the self-write timer
// - Code protect blocks external accesses only
// - Ten-bit address, two high bits used
// - Writes blocked during power-up timer
module deac_ctrl
    import deac_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ext_access_i,
    // Device pins
    input wire logic code_protect_i,
    input wire logic slow_crystal_mode_i,
    input wire logic pwrt_busy_i,
    input wire logic [21:0] table_pointer_i,
    // Array side
    output logic [9:0] nv_addr_o,
    output logic [7:0] nv_wdata_o,
    output logic nv_rd_o,
    input wire logic [7:0] nv_rdata_i,
    output logic data_wr_o,
    output logic flash_op_o,
    output logic cfg_op_o,
    output logic row_erase_o,
    output logic [21:0] row_addr_o,
    output logic high_power_osc_o
);
    typedef struct packed {
        logic [7:0] prdata;
        logic pready;
        logic pslverr;
        logic cs;
        logic ss;
        logic row;
        logic abort;
        logic allow;
        logic launch;
        logic fetch;
        logic [7:0] buff;
        logic [7:0] alo;
        logic [1:0] ahi;
        logic done_flag;
        logic op_data;
        logic op_flash;
        logic op_cfg;
        logic op_erase;
        logic [21:0] row_addr;
        logic hp_osc;
        logic cp1;
        logic cp2;
        logic lp1;
        logic lp2;
        logic pw1;
        logic pw2;
    } deac_st_t;

    deac_st_t r;
    deac_st_t n;

    logic setup;
    logic acc_wr;
    logic mapped;
    logic wr_ctrl;
    logic wr_key;
    logic wr_buf;
    logic wr_alo;
    logic wr_ahi;
    logic wr_flag;
    logic ext_locked;
    logic armed;
    logic start;
    logic done;
    logic [7:0] wd;
    logic [7:0] ctrl_rd;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    assign wd = pwdata_i[7:0];
    assign setup = psel_i && !penable_i;
    // pready is registered high in every access phase
    assign acc_wr = psel_i && penable_i && r.pready && pwrite_i;
    assign mapped = hit(paddr_i, OFS_CTRL) || hit(paddr_i, OFS_KEY)
        || hit(paddr_i, OFS_BUF) || hit(paddr_i, OFS_ALO)
        || hit(paddr_i, OFS_AHI) || hit(paddr_i, OFS_FLAG);
    assign wr_ctrl = acc_wr && hit(paddr_i, OFS_CTRL);
    assign wr_key = acc_wr && hit(paddr_i, OFS_KEY);
    assign wr_buf = acc_wr && hit(paddr_i, OFS_BUF);
    assign wr_alo = acc_wr && hit(paddr_i, OFS_ALO);
    assign wr_ahi = acc_wr && hit(paddr_i, OFS_AHI);
    assign wr_flag = acc_wr && hit(paddr_i, OFS_FLAG);
    // Internal core accesses pass regardless of protection
    assign ext_locked = ext_access_i && r.cp2;
    assign ctrl_rd = {r.cs, r.ss, 1'b0, r.row, r.abort, r.allow,
        r.launch, r.fetch};

    // Allow must already be set; a write setting both is refused
    assign start = wr_ctrl && wd[B_LCH] && !r.launch && r.allow
        && armed
        && !r.pw2
        && !ext_locked;

    deac_unlock u_unlock (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .key_wr_i(wr_key),
        .key_byte_i(wd),
        .other_wr_i(acc_wr && !wr_key),
        .armed_o(armed)
    );

    // The timer halts while the synchronised slow crystal mode input stands
    deac_timer #(.CYCLES(WRITE_CYC)) u_timer (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .start_i(start),
        .run_i(!r.lp2),
        .done_o(done)
    );

    always_comb begin
        n = r;
        n.cp1 = code_protect_i;
        n.cp2 = r.cp1;
        n.lp1 = slow_crystal_mode_i;
        n.lp2 = r.lp1;
        n.pw1 = pwrt_busy_i;
        n.pw2 = r.pw1;
        n.pready = setup;
        n.pslverr = setup && !mapped;
        n.prdata = RST_BYTE;
        if (setup && !pwrite_i) begin
            if (hit(paddr_i, OFS_CTRL)) begin
                n.prdata = ctrl_rd;
            end else if (hit(paddr_i, OFS_BUF)) begin
                n.prdata = ext_locked ? RST_BYTE : r.buff;
            end else if (hit(paddr_i, OFS_ALO)) begin
                n.prdata = r.alo;
            end else if (hit(paddr_i, OFS_AHI)) begin
                n.prdata = {6'h00, r.ahi};
            end else if (hit(paddr_i, OFS_FLAG)) begin
                n.prdata = {3'h0, r.done_flag, 4'h0};
            end
            // The key port falls through and reads zero
        end
        if (wr_ctrl && !r.launch) begin
            n.cs = wd[B_CS];
            n.ss = wd[B_SS];
            n.row = wd[B_ROW];
            n.abort = wd[B_ABT];
            n.allow = wd[B_ALW];
            if (wd[B_ALW] && !r.allow) begin
                n.abort = 1'b1;
            end
            // Launch and fetch are set-only; a zero write keeps them
            // A fetch riding on a launch write would clobber the byte
            // being stored, so the launch takes priority
            if (wd[B_FET] && !wd[B_CS] && !wd[B_SS]
                && !ext_locked && !start) begin
                n.fetch = 1'b1;
            end
        end
        if (start) begin
            n.launch = 1'b1;
            n.hp_osc = 1'b1;
            n.op_cfg = wd[B_SS];
            n.op_flash = !wd[B_SS] && wd[B_CS];
            n.op_data = !wd[B_SS] && !wd[B_CS];
            n.op_erase = wd[B_ROW] && !wd[B_SS] && wd[B_CS];
            n.row_addr = table_pointer_i;
        end else if (wr_ctrl && wd[B_LCH] && !r.launch) begin
            // Space selects stay as written so the failure is traceable
            n.abort = 1'b1;
        end
        if (wr_buf && !r.launch) begin
            n.buff = wd;
        end
        // Array data is sampled while the read strobe stands
        if (r.fetch) begin
            n.fetch = 1'b0;
            n.buff = nv_rdata_i;
        end
        if (wr_alo && !r.launch) begin
            n.alo = wd;
        end
        if (wr_ahi && !r.launch) begin
            n.ahi = wd[1:0];
        end
        if (wr_flag) begin
            n.done_flag = r.done_flag && wd[B_DONE];
        end
        // Completion is applied last so it wins over a flag clear
        if (done) begin
            n.launch = 1'b0;
            n.done_flag = 1'b1;
            n.abort = 1'b0;
            n.hp_osc = 1'b0;
            n.op_data = 1'b0;
            n.op_flash = 1'b0;
            n.op_cfg = 1'b0;
            n.op_erase = 1'b0;
            if (r.op_erase) begin
                n.row = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '0;
            r.abort <= RST_ABORT;
        end else begin
            r <= n;
        end
    end

    assign prdata_o = {24'h000000, r.prdata};
    assign pready_o = r.pready;
    assign pslverr_o = r.pslverr;
    assign nv_addr_o = {r.ahi, r.alo};
    assign nv_wdata_o = r.buff;
    assign nv_rd_o = r.fetch;
    assign data_wr_o = r.op_data;
    assign flash_op_o = r.op_flash;
    assign cfg_op_o = r.op_cfg;
    assign row_erase_o = r.op_erase;
    assign row_addr_o = r.row_addr;
    assign high_power_osc_o = r.hp_osc;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // Fetch and buffer
    fetch_pulse_a: assert property (r.fetch |=> !r.fetch)
        else $error("fetch_trigger held longer than one cycle");
    fetch_data_a: assert property (
        r.fetch |=> r.buff == $past(nv_rdata_i))
        else $error("fetched byte not captured");
    fetch_space_a: assert property (r.fetch |-> !r.cs && !r.ss)
        else $error("fetch in non-data space");
    fetch_ignore_a: assert property (
        wr_ctrl && (wd[B_CS] || wd[B_SS]) |=> !r.fetch)
        else $error("fetch started in flash or settings space");
    buf_write_a: assert property (
        wr_buf && !r.launch && !r.fetch |=> r.buff == $past(wd))
        else $error("buffer write lost");

    // Launch, refusal and completion
    launch_hold_a: assert property (r.launch && !done |=> r.launch)
        else $error("program_launch dropped early");
    launch_osc_a: assert property (start |=> r.launch && r.hp_osc)
        else $error("launch did not raise the oscillator");
    slow_stall_a: assert property (r.lp2 |=> !done)
        else $error("write timer ran in slow crystal mode");
    done_flag_a: assert property (
        done |=> !r.launch && r.done_flag)
        else $error("completion did not update flags");
    flag_keep_a: assert property (
        r.done_flag && !wr_flag |=> r.done_flag)
        else $error("write_done_flag cleared by hardware");
    done_abort_a: assert property (done |=> !r.abort)
        else $error("abort flag left set after completion");
    erase_clear_a: assert property (
        done && r.op_erase |=> !r.row && !r.op_erase)
        else $error("row erase enable kept after erase");
    allow_prior_a: assert property (
        wr_ctrl && wd[B_LCH] && !r.launch && !r.allow |=> !r.launch)
        else $error("launch without prior allow_program");
    key_armed_a: assert property (
        wr_ctrl && wd[B_LCH] && !r.launch && !armed
        |=> !r.launch && r.abort)
        else $error("launch without unlock sequence");
    abort_trace_a: assert property (
        wr_ctrl && wd[B_LCH] && !r.launch && !start
        |=> r.abort && r.cs == $past(wd[B_CS]) && r.ss == $past(wd[B_SS]))
        else $error("space select lost at abort");
    pwrt_block_a: assert property (r.pw2 && !r.launch |=> !r.launch)
        else $error("launch during power-up timer");

    // Register side
    busy_freeze_a: assert property (r.launch && $past(r.launch)
        |-> $stable(r.alo) && $stable(r.ahi) && $stable(r.cs)
        && $stable(r.ss) && $stable(r.buff))
        else $error("state changed during write");
    busy_fetch_a: assert property (r.launch |-> !r.fetch)
        else $error("array read during a timed write");
    allow_keep_a: assert property (
        r.allow && !wr_ctrl |=> r.allow)
        else $error("allow_program cleared by hardware");
    ahi_write_a: assert property (
        wr_ahi && !r.launch |=> r.ahi == $past(wd[1:0]))
        else $error("address high bits not taken");
    key_read_a: assert property (setup && !pwrite_i
        && hit(paddr_i, OFS_KEY) |=> r.prdata == RST_BYTE)
        else $error("key port read nonzero");
    ext_read_a: assert property (
        setup && !pwrite_i && hit(paddr_i, OFS_BUF) && ext_locked
        |=> r.prdata == RST_BYTE)
        else $error("protected buffer visible outside");

    // Space steering
    one_space_a: assert property (
        r.launch |-> $onehot({r.op_data, r.op_flash, r.op_cfg}))
        else $error("launched operation has no single target");

    launch_c: cover property (start);
    finish_c: cover property (done);
    fetch_c: cover property (r.fetch);
    refuse_c: cover property (wr_ctrl && wd[B_LCH] && !start);
    erase_c: cover property (start && wd[B_ROW] && wd[B_CS]);
endmodule

// ==== deac_pkg.sv ====
// Constants and types shared by the data array access controller
package deac_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_KEY = 8'h04;
    localparam logic [7:0] OFS_BUF = 8'h08;
    localparam logic [7:0] OFS_ALO = 8'h0C;
    localparam logic [7:0] OFS_AHI = 8'h10;
    localparam logic [7:0] OFS_FLAG = 8'h14;

    // Field positions in memory_access_control
    localparam int B_CS = 7;
    localparam int B_SS = 6;
    localparam int B_ROW = 4;
    localparam int B_ABT = 3;
    localparam int B_ALW = 2;
    localparam int B_LCH = 1;
    localparam int B_FET = 0;
    // Field position in flag_register_six
    localparam int B_DONE = 4;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic RST_ABORT = 1'b1;

    // Unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Self-timed write duration
    localparam int CLK_PERIOD_NS = 25;
    localparam int WRITE_TIME_NS = 4000000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_ARMED = 2'b11
    } deac_key_t;

endpackage

// ==== deac_timer.sv ====
// Self-timed write duration counter
`timescale 1ns/1ps
module deac_timer
    import deac_pkg::*;
#(
    parameter int CYCLES = WRITE_CYCLES
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic start_i,
    input wire logic run_i,
    // Completion
    output logic done_o
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    typedef struct packed {
        logic busy;
        logic [W-1:0] cnt;
        logic done;
    } deac_tmr_t;

    deac_tmr_t r;
    deac_tmr_t n;

    // Counting pauses while run_i is low, stretching the operation
    always_comb begin
        n = r;
        n.done = 1'b0;
        if (start_i) begin
            n.busy = 1'b1;
            n.cnt = '0;
        end else if (r.busy && run_i) begin
            if (r.cnt == LAST) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.cnt = r.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign done_o = r.done;
endmodule

// ==== deac_unlock.sv ====
// Unlock key sequence checker
`timescale 1ns/1ps
module deac_unlock
    import deac_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Bus write events
    input wire logic key_wr_i,
    input wire logic [7:0] key_byte_i,
    input wire logic other_wr_i,
    // Result
    output logic armed_o
);
    typedef struct packed {
        deac_key_t st;
    } deac_unl_t;

    deac_unl_t r;
    deac_unl_t n;

    // Any other write breaks the sequence, so it arms one write only
    always_comb begin
        n = r;
        if (other_wr_i) begin
            n.st = KEY_IDLE;
        end else if (key_wr_i) begin
            unique case (r.st)
                KEY_IDLE: begin
                    n.st = (key_byte_i == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
                end
                KEY_HALF: begin
                    n.st = (key_byte_i == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
                end
                KEY_ARMED: begin
                    n.st = KEY_IDLE;
                end
                default: begin
                    n.st = KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r.st <= KEY_IDLE;
        end else begin
            r <= n;
        end
    end

    assign armed_o = (r.st == KEY_ARMED);
endmodule

// ==== test_deac_ctrl.sv ====
// Self-checking bench for the data array access controller
`timescale 1ns/1ps
module test_deac_ctrl;
    import deac_pkg::*;
    localparam int WCYC = 8;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic ext_access_i = 1'b0;
    logic code_protect_i = 1'b0;
    logic slow_crystal_mode_i = 1'b0;
    logic pwrt_busy_i = 1'b0;
    logic [21:0] table_pointer_i = 22'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, nv_rd_o, data_wr_o, flash_op_o, cfg_op_o;
    logic row_erase_o, high_power_osc_o;
    logic [9:0] nv_addr_o;
    logic [7:0] nv_wdata_o, nv_rdata_i;
    logic [21:0] row_addr_o;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int checks_done = 0;
    int rd_cnt = 0;
    logic [7:0] rp [4] = '{8'h80, 8'h04, 8'h04, 8'h04};
    logic [7:0] rf [4] = '{8'h86, 8'h06, 8'h06, 8'h06};
    logic [7:0] re [4] = '{8'h8C, 8'h0C, 8'h0C, 8'h0C};

    always #12.5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (nv_rd_o === 1'b1) begin
            rd_cnt++;
        end
    end

    deac_ctrl #(.WRITE_CYC(WCYC)) deac_ctrl_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .ext_access_i(ext_access_i),
        .code_protect_i(code_protect_i),
        .slow_crystal_mode_i(slow_crystal_mode_i),
        .pwrt_busy_i(pwrt_busy_i), .table_pointer_i(table_pointer_i),
        .nv_addr_o(nv_addr_o), .nv_wdata_o(nv_wdata_o), .nv_rd_o(nv_rd_o),
        .nv_rdata_i(nv_rdata_i), .data_wr_o(data_wr_o),
        .flash_op_o(flash_op_o), .cfg_op_o(cfg_op_o),
        .row_erase_o(row_erase_o), .row_addr_o(row_addr_o),
        .high_power_osc_o(high_power_osc_o)
    );

    deac_array_model deac_array_model_i (
        .clk_i(clk_i), .nv_addr_i(nv_addr_o), .nv_wdata_i(nv_wdata_o),
        .nv_rd_i(nv_rd_o), .data_wr_i(data_wr_o), .nv_rdata_o(nv_rdata_i)
    );

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        cmp(rd, {24'h0, e});
    endtask

    // Pre value twice: second write clears the abort raised by allow
    task automatic launch(input logic [7:0] pre, input logic [7:0] fin,
                          input logic brk);
        wr(OFS_CTRL, pre);
        wr(OFS_CTRL, pre);
        wr(OFS_KEY, KEY_FIRST);
        if (brk) begin
            wr(OFS_BUF, 8'h33);
        end
        wr(OFS_KEY, KEY_SECOND);
        wr(OFS_CTRL, fin);
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wait_idle;
        do begin
            apb(1'b0, OFS_CTRL, 8'h00);
        end while (rd[B_LCH] !== 1'b0);
    endtask

    initial begin
        logic [3:0] ops [2];
        logic [7:0] sp [2];
        ops = '{4'b0101, 4'b0010};
        sp = '{8'h94, 8'h44};
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        chk(OFS_CTRL, 8'h08); // Reset image
        wr(OFS_KEY, 8'h5A);
        chk(OFS_KEY, 8'h00); // Key reads zero
        apb(1'b0, 8'h18, 8'h00);
        cmp({31'h0, er}, 32'h1);
        wr(OFS_AHI, 8'hFF);
        wr(OFS_ALO, 8'hFF);
        wr(OFS_BUF, 8'hA5);
        // Slow crystal stalls the timer so the busy window is wide
        slow_crystal_mode_i <= 1'b1;
        launch(8'h04, 8'h06, 1'b0); // Good sequence
        cmp({22'h0, nv_addr_o}, 32'h3FF); // Top address
        cmp({28'h0, data_wr_o, flash_op_o, cfg_op_o, high_power_osc_o},
            32'h9); // Data space
        wr(OFS_CTRL, 8'h00);
        wr(OFS_BUF, 8'h11);
        wr(OFS_ALO, 8'h00);
        chk(OFS_CTRL, 8'h06); // Still busy
        chk(OFS_BUF, 8'hA5); // Buffer frozen
        slow_crystal_mode_i <= 1'b0;
        wait_idle();
        chk(OFS_CTRL, 8'h04); // Done state
        chk(OFS_FLAG, 8'h10); // Done flag
        wr(OFS_FLAG, 8'h00);
        chk(OFS_FLAG, 8'h00); // Software clear
        wr(OFS_BUF, 8'h00);
        wr(OFS_CTRL, 8'h01);
        chk(OFS_BUF, 8'hA5); // Fetched byte
        chk(OFS_CTRL, 8'h00); // Fetch self-clears
        wr(OFS_BUF, 8'h33);
        wr(OFS_CTRL, 8'h81);
        chk(OFS_BUF, 8'h33); // No fetch in flash space
        cmp(32'(rd_cnt), 32'h1); // One array read
        table_pointer_i <= 22'h2ABCDE;
        for (int i = 0; i < 2; i++) begin
            launch(sp[i], sp[i] | 8'h02, 1'b0);
            cmp({28'h0, data_wr_o, flash_op_o, cfg_op_o, row_erase_o},
                {28'h0, ops[i]}); // Space steering
            cmp({10'h0, row_addr_o}, 32'h2ABCDE); // Row pointer
            wait_idle();
            chk(OFS_CTRL, sp[i] & 8'hE7); // Erase bit cleared
        end
        for (int m = 0; m < 4; m++) begin
            pwrt_busy_i <= (m == 1);
            code_protect_i <= (m == 2);
            ext_access_i <= (m == 2);
            repeat (3) @(posedge clk_i);
            launch(rp[m], rf[m], m == 3);
            cmp({31'h0, data_wr_o}, 32'h0); // Nothing starts
            chk(OFS_CTRL, re[m]); // Abort kept
        end
        pwrt_busy_i <= 1'b0;
        code_protect_i <= 1'b1;
        ext_access_i <= 1'b1;
        // Protection pin must pass its synchroniser first
        repeat (3) @(posedge clk_i);
        chk(OFS_BUF, 8'h00); // Hidden from outside
        ext_access_i <= 1'b0;
        chk(OFS_BUF, 8'h33); // Visible to the core
        launch(8'h04, 8'h06, 1'b0);
        cmp({31'h0, data_wr_o}, 32'h1); // Core write allowed
        rst_b_i <= 1'b0;
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        chk(OFS_CTRL, 8'h08); // Reset during write
        cmp({31'h0, data_wr_o}, 32'h0); // Write cut by reset
        complete_run();
    end

    initial begin
        #(25 * 20000);
        err_total++;
        $display("BAD %0t watchdog", $time);
        complete_run();
    end
endmodule
